// ===== pkg/erai_pkg.sv
package erai_pkg;

	// Timing of the frame-loss decision at a 10 MHz core clock.
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned LOF_SHORT_NS  = 1_000_000;
	localparam int unsigned LOF_LONG_NS   = 3_000_000;
	localparam int unsigned LOF_SHORT_CYC = (LOF_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned LOF_LONG_CYC  = (LOF_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          LOF_CNT_W     = 16;

	// Frame-level thresholds.
	localparam logic [2:0] OOF_ERR_FRAMES  = 3'h4;
	localparam logic [8:0] AIS_DECLARE_MAX = 9'h007;
	localparam logic [7:0] AIS_CLEAR_MIN   = 8'h08;
	localparam logic [7:0] ZCNT_SAT        = 8'hFF;

	// Register indices; the byte address is four times the index.
	localparam logic [5:0] REG_CFG2_IDX = 6'h11;
	localparam logic [5:0] REG_EN1_IDX  = 6'h12;
	localparam logic [5:0] REG_EN2_IDX  = 6'h13;
	localparam logic [5:0] REG_ST1_IDX  = 6'h14;
	localparam logic [5:0] REG_ST2_IDX  = 6'h15;

	// Field positions.
	localparam int CFG2_ALGO_BIT = 7;
	localparam int CFG2_LOF_BIT  = 6;
	localparam int CFG2_OOF_BIT  = 5;
	localparam int CFG2_LOS_BIT  = 4;
	localparam int CFG2_AIS_BIT  = 3;
	localparam int CFG2_FERF_BIT = 0;
	localparam int INT1_ALCHG_BIT = 4;
	localparam int INT1_OOF_BIT  = 3;
	localparam int INT1_LOF_BIT  = 2;
	localparam int INT1_LOS_BIT  = 1;
	localparam int INT1_AIS_BIT  = 0;
	localparam int INT2_FERF_BIT = 3;

	// Values after reset and writable masks.
	localparam logic [7:0] CFG2_RESET = 8'h67;
	localparam logic [1:0] CFG2_RSVD  = 2'h3;
	localparam logic [7:0] EN1_RESET  = 8'h00;
	localparam logic [7:0] EN2_RESET  = 8'h00;
	localparam logic [7:0] STAT_RESET = 8'h00;
	localparam logic [7:0] EN1_MASK   = 8'h1F;
	localparam logic [7:0] EN2_MASK   = 8'h08;
	localparam logic [7:0] ALIGN_RESET = 8'h00;

	typedef enum logic [1:0] {
		ERAI_IN_FRAME = 2'b00,
		ERAI_OOF      = 2'b01,
		ERAI_LOF      = 2'b11
	} erai_frm_state_t;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [7:0]  address;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} erai_avm_req_t;

	typedef struct packed {
		logic       frame_start;
		logic       bit_valid;
		logic       bit_data;
		logic       fas_error;
		logic       a_bit;
		logic       resync;
		logic [7:0] resync_pos;
	} erai_rx_t;

endpackage

// ===== rtl/erai_top.sv
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/10ps
// Summary of operation
// - Frame-loss change enable sits in enable register 1, bit 2 as mapped.
// - An enable bit at one allows its interrupt; at zero suppresses it.
// - Any enabled pending alarm interrupt drives the request output low.
// - Frame-loss change sets status register 1 bit 2 as mapped.
// - Alarm indication change interrupts on both declare and clear.
// - Declare alarm indication at seven or fewer zeros over two frames.
// - Clear alarm indication after two frames each holding eight or more zeros.
// - Alarm indication change enable is enable register 1 bit 0.
// - Alarm indication change sets status register 1 bit 0.
// - Condition register 2 bit 3 shows live alarm indication state.
// - Alignment change interrupts on an abrupt change of frame alignment.
// - Four errored alignment frames declare out-of-frame; old alignment is kept.
// - Alignment change fires only when resync used a different alignment.
// - Alignment change enable is enable register 1 bit 4, read-write.
// - Alignment change sets status register 1 bit 4.
// - A-bit one frames declare far-end failure and raise its change interrupt.
// - A-bit zero frames clear far-end failure and raise its change interrupt.
// - Frame loss after out-of-frame lasts 1 ms or 3 ms, per algorithm bit.
// - Far-end failure change enable is enable register 2 bit 3.
module erai_top #(
	parameter int unsigned LOF_SHORT_CYCLES = erai_pkg::LOF_SHORT_CYC,
	parameter int unsigned LOF_LONG_CYCLES  = erai_pkg::LOF_LONG_CYC
) (
	// Clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    reset_n,
	// Avalon-MM slave
	input  wire erai_pkg::erai_avm_req_t avm_req,
	output logic [31:0]                  avm_readdata,
	output logic                         avm_waitrequest,
	// Receive framer side
	input  wire erai_pkg::erai_rx_t      rx_in,
	input  wire logic                    signal_loss_state,
	output logic [7:0]                   active_alignment,
	output logic                         out_of_frame_state,
	output logic                         frame_loss_state,
	output logic                         alarm_indication_state,
	output logic                         far_end_failure_state,
	// Host interrupt
	output logic                         irq_n
);
	import erai_pkg::*;

	function automatic logic reg_hit(input logic [7:0] addr, input logic [5:0] idx);
		return addr == {idx, 2'b00};
	endfunction

	// Saturating zero counter step; saturation keeps long frames from wrapping.
	function automatic logic [7:0] zero_add(input logic [7:0] base, input logic valid,
		input logic data);
		return (valid && !data && base != ZCNT_SAT) ? base + 8'h01 : base;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Bus slave: every access waits one cycle, so read data can be registered.

	logic        ack_q;
	logic [31:0] rdata_q;
	logic        algo_q;
	logic [7:0]  en1_q;
	logic [7:0]  en2_q;
	logic [7:0]  st1_q;
	logic [7:0]  st2_q;
	logic [7:0]  st1_d;
	logic [7:0]  st2_d;
	logic [7:0]  en1_d;
	logic [7:0]  en2_d;
	logic        algo_d;

	wire req       = avm_req.read | avm_req.write;
	wire accept    = req & ack_q;
	wire rd_accept = accept & avm_req.read;
	wire wr_accept = accept & avm_req.write & avm_req.byteenable[0];
	wire hit_cfg2  = reg_hit(avm_req.address, REG_CFG2_IDX);
	wire hit_en1   = reg_hit(avm_req.address, REG_EN1_IDX);
	wire hit_en2   = reg_hit(avm_req.address, REG_EN2_IDX);
	wire hit_st1   = reg_hit(avm_req.address, REG_ST1_IDX);
	wire hit_st2   = reg_hit(avm_req.address, REG_ST2_IDX);
	wire [7:0] wbyte = avm_req.writedata[7:0];

	assign avm_waitrequest = req & ~ack_q;
	assign avm_readdata    = rdata_q;

	////////////////////////////////////////////////////////////////////////////
	// Receive condition state.

	erai_frm_state_t      frm_q;
	erai_frm_state_t      frm_d;
	logic [2:0]           fas_cnt_q;
	logic [2:0]           fas_cnt_d;
	logic [LOF_CNT_W-1:0] lof_cnt_q;
	logic [7:0]           align_q;
	logic [7:0]           zcnt_q;
	logic [7:0]           zprev_q;
	logic                 ais_q;
	logic                 ais_d;
	logic                 ferf_q;
	logic                 los_q;

	wire fs         = rx_in.frame_start;
	wire in_frame   = (frm_q == ERAI_IN_FRAME);
	wire oof_now    = ~in_frame;
	wire lof_now    = (frm_q == ERAI_LOF);
	wire resync_hit = rx_in.resync & ~in_frame;
	wire [LOF_CNT_W-1:0] lof_limit = algo_q ? LOF_CNT_W'(LOF_LONG_CYCLES)
		: LOF_CNT_W'(LOF_SHORT_CYCLES);
	wire lof_expire = (frm_q == ERAI_OOF) && (lof_cnt_q == lof_limit - 16'h0001);
	wire [8:0] zsum = {1'b0, zprev_q} + {1'b0, zcnt_q};
	wire ais_set    = fs & ~ais_q & (zsum <= AIS_DECLARE_MAX);
	wire ais_clr    = fs & ais_q & (zprev_q >= AIS_CLEAR_MIN)
		& (zcnt_q >= AIS_CLEAR_MIN);
	wire ferf_d     = fs ? rx_in.a_bit : ferf_q;

	always_comb begin
		frm_d     = frm_q;
		fas_cnt_d = fas_cnt_q;
		unique case (frm_q)
			ERAI_IN_FRAME: begin
				if (fs && rx_in.fas_error) begin
					fas_cnt_d = fas_cnt_q + 3'h1;
					if (fas_cnt_q + 3'h1 == OOF_ERR_FRAMES) begin
						frm_d     = ERAI_OOF;
						fas_cnt_d = 3'h0;
					end
				end else if (fs) begin
					fas_cnt_d = 3'h0;
				end
			end
			ERAI_OOF: begin
				if (rx_in.resync) begin
					frm_d = ERAI_IN_FRAME;
				end else if (lof_expire) begin
					frm_d = ERAI_LOF;
				end
			end
			ERAI_LOF: begin
				if (rx_in.resync) begin
					frm_d = ERAI_IN_FRAME;
				end
			end
			default: begin
				frm_d = ERAI_LOF;
			end
		endcase
	end

	assign ais_d = ais_set ? 1'b1 : (ais_clr ? 1'b0 : ais_q);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			frm_q     <= ERAI_LOF;
			fas_cnt_q <= 3'h0;
			lof_cnt_q <= '0;
		end else begin
			frm_q     <= frm_d;
			fas_cnt_q <= fas_cnt_d;
			lof_cnt_q <= (frm_q == ERAI_OOF) ? lof_cnt_q + 16'h0001 : '0;
		end
	end

	// Payload keeps the old alignment until the framer reports a resync while out of frame.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			align_q <= ALIGN_RESET;
		end else if (resync_hit) begin
			align_q <= rx_in.resync_pos;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			zcnt_q  <= 8'h00;
			zprev_q <= ZCNT_SAT;
		end else if (fs) begin
			zprev_q <= zcnt_q;
			zcnt_q  <= zero_add(8'h00, rx_in.bit_valid, rx_in.bit_data);
		end else begin
			zcnt_q  <= zero_add(zcnt_q, rx_in.bit_valid, rx_in.bit_data);
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ais_q  <= CFG2_RESET[CFG2_AIS_BIT];
			ferf_q <= CFG2_RESET[CFG2_FERF_BIT];
			los_q  <= CFG2_RESET[CFG2_LOS_BIT];
		end else begin
			ais_q  <= ais_d;
			ferf_q <= ferf_d;
			los_q  <= signal_loss_state;
		end
	end

	assign active_alignment       = align_q;
	assign out_of_frame_state     = oof_now;
	assign frame_loss_state       = lof_now;
	assign alarm_indication_state = ais_q;
	assign far_end_failure_state  = ferf_q;

	////////////////////////////////////////////////////////////////////////////
	// Change events, sticky status and the request pin.

	wire oof_next  = (frm_d != ERAI_IN_FRAME);
	wire lof_next  = (frm_d == ERAI_LOF);
	wire alchg_evt = resync_hit & (rx_in.resync_pos != align_q);
	wire ais_chg   = ais_d != ais_q;
	wire ferf_chg  = ferf_d != ferf_q;
	wire los_chg   = signal_loss_state != los_q;
	wire [7:0] set1 = {3'h0, alchg_evt & en1_q[INT1_ALCHG_BIT],
		(oof_next != oof_now) & en1_q[INT1_OOF_BIT],
		(lof_next != lof_now) & en1_q[INT1_LOF_BIT],
		los_chg & en1_q[INT1_LOS_BIT], ais_chg & en1_q[INT1_AIS_BIT]};
	wire [7:0] set2 = {4'h0, ferf_chg & en2_q[INT2_FERF_BIT], 3'h0};
	wire [7:0] cfg2_rd = {algo_q, lof_now, oof_now, los_q, ais_q, CFG2_RSVD, ferf_q};
	wire [7:0] rd_byte = hit_cfg2 ? cfg2_rd
		: hit_en1 ? en1_q
		: hit_en2 ? en2_q
		: hit_st1 ? st1_q
		: hit_st2 ? st2_q
		: 8'h00;

	// A set in the clearing cycle wins; one set in the wait cycle before it is cleared unread.
	assign st1_d  = (st1_q & ~((rd_accept && hit_st1) ? 8'hFF : 8'h00)) | set1;
	assign st2_d  = (st2_q & ~((rd_accept && hit_st2) ? 8'hFF : 8'h00)) | set2;
	assign en1_d  = (wr_accept && hit_en1) ? (wbyte & EN1_MASK) : en1_q;
	assign en2_d  = (wr_accept && hit_en2) ? (wbyte & EN2_MASK) : en2_q;
	assign algo_d = (wr_accept && hit_cfg2) ? wbyte[CFG2_ALGO_BIT] : algo_q;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q   <= req & ~ack_q;
			rdata_q <= (req && !ack_q) ? {24'h00_0000, rd_byte} : rdata_q;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			algo_q <= CFG2_RESET[CFG2_ALGO_BIT];
			en1_q  <= EN1_RESET;
			en2_q  <= EN2_RESET;
			st1_q  <= STAT_RESET;
			st2_q  <= STAT_RESET;
			irq_n  <= 1'b1;
		end else begin
			algo_q <= algo_d;
			en1_q  <= en1_d;
			en2_q  <= en2_d;
			st1_q  <= st1_d;
			st2_q  <= st2_d;
			irq_n  <= ~|((st1_q & en1_q) | (st2_q & en2_q));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	a_irq_pending_low: assert property (
		((st1_q & en1_q) != 8'h00) |=> !irq_n)
		else $error("request pin not low with an enabled pending status");
	a_irq_idle_high: assert property (
		(((st1_q & en1_q) | (st2_q & en2_q)) == 8'h00) |=> irq_n)
		else $error("request pin low with nothing pending");
	a_ais_status_set: assert property (
		(ais_chg && en1_q[INT1_AIS_BIT]) |=> st1_q[INT1_AIS_BIT] ##1 !irq_n)
		else $error("alarm change did not set status and request");
	a_enable_gates: assert property (
		(!en1_q[INT1_AIS_BIT] && !st1_q[INT1_AIS_BIT]) |=> !st1_q[INT1_AIS_BIT])
		else $error("disabled alarm change set its status");
	a_align_chg_cause: assert property (
		$rose(st1_q[INT1_ALCHG_BIT]) |-> $past(resync_hit)
		&& ($past(rx_in.resync_pos) != $past(align_q)))
		else $error("alignment status set without a changed resync");
	a_oof_four_errs: assert property (
		(in_frame && fs && rx_in.fas_error && fas_cnt_q == 3'h3) |=> out_of_frame_state)
		else $error("fourth errored frame did not declare out-of-frame");
	a_align_hold: assert property (
		(!resync_hit) |=> $stable(align_q))
		else $error("alignment moved without a resync");
	a_lof_timeout: assert property (
		(lof_expire && !rx_in.resync) |=> frame_loss_state)
		else $error("frame loss not declared at timeout");
	a_ais_declare: assert property (
		(fs && zsum <= AIS_DECLARE_MAX) |=> alarm_indication_state)
		else $error("alarm indication not declared on few zeros");
	a_ais_clear: assert property (
		(fs && ais_q && zprev_q >= AIS_CLEAR_MIN && zcnt_q >= AIS_CLEAR_MIN
		&& zsum > AIS_DECLARE_MAX) |=> !alarm_indication_state)
		else $error("alarm indication not cleared");
	a_ferf_follow: assert property (
		fs |=> far_end_failure_state == $past(rx_in.a_bit))
		else $error("far-end failure does not follow A bit");
	a_ferf_status: assert property (
		(ferf_chg && en2_q[INT2_FERF_BIT]) |=> st2_q[INT2_FERF_BIT])
		else $error("far-end change did not set status");
	a_read_clears: assert property (
		(rd_accept && hit_st1 && set1 == 8'h00) |=> st1_q == 8'h00)
		else $error("status not cleared by read");
	a_cfg2_ais_view: assert property (
		(rd_accept && hit_cfg2) |-> avm_readdata[CFG2_AIS_BIT] == $past(ais_q))
		else $error("condition register shows wrong alarm state");

	c_ais_irq: cover property (ais_set && en1_q[INT1_AIS_BIT] ##[1:4] !irq_n);
	c_align_chg: cover property (alchg_evt && en1_q[INT1_ALCHG_BIT]);
	c_lof: cover property (frm_q == ERAI_OOF ##1 frm_q == ERAI_LOF);
	c_read_clear: cover property (rd_accept && hit_st1 && st1_q != 8'h00);

endmodule

// ===== test/erai_far_end.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Remote terminal: back-to-back frames of FRAME_BITS bits, the first ones zero.
module erai_far_end #(
	parameter int FRAME_BITS = 16
) (
	// Clock and reset
	input  wire logic               core_clk,
	input  wire logic               reset_n,
	// Frame content
	input  wire logic [7:0]         zeros,
	input  wire logic               a_val,
	input  wire logic               fas_val,
	input  wire logic               resync_req,
	input  wire logic [7:0]         resync_at,
	// Line
	output erai_pkg::erai_rx_t      rx
);
	import erai_pkg::*;
	logic [7:0] bit_q;
	logic [7:0] zeros_q;
	logic       run_q;
	wire        first_bit = run_q && (bit_q == 8'h00);
	wire  [7:0] zeros_now = (bit_q == 8'h00) ? zeros : zeros_q;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			bit_q   <= 8'h00;
			zeros_q <= 8'h00;
			run_q   <= 1'h0;
		end else begin
			run_q   <= 1'h1;
			bit_q   <= (bit_q == 8'(FRAME_BITS - 1)) ? 8'h00 : bit_q + 8'h01;
			zeros_q <= zeros_now;
		end
	end
	// Zero count is latched per frame so a change lands on a frame boundary.
	assign rx.frame_start = first_bit;
	assign rx.bit_valid   = run_q;
	assign rx.bit_data    = run_q ? (bit_q >= zeros_now) : bit_q[0];
	// Frame flags only mean something at a frame start; elsewhere the A bit is inverted and the FAS error is held low.
	assign rx.fas_error   = first_bit & fas_val;
	assign rx.a_bit       = first_bit ? a_val : ~a_val;
	assign rx.resync      = resync_req;
	assign rx.resync_pos  = resync_at;
endmodule

// ===== test/tb.sv
`timescale 1ns/10ps
module tb;
	import erai_pkg::*;
	localparam int FB = 16;
	typedef struct packed {
		logic       wr;
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] e;
	} erai_row_t;
	logic          core_clk;
	logic          reset_n;
	logic          los;
	logic          a_val;
	logic          fas_val;
	logic          rsy;
	logic [7:0]    zeros;
	logic [7:0]    rsy_pos;
	logic [7:0]    rd;
	logic [7:0]    act_al;
	logic [31:0]   rdata;
	logic          wreq;
	logic          irq_n;
	logic          oof;
	logic          lof;
	logic          ais;
	logic          ferf;
	erai_avm_req_t avm_req;
	erai_rx_t      rx;
	int            n_fail = 0;
	int            num_checks = 0;
	wire [3:0]     st = {lof, oof, ais, ferf};
	erai_row_t     rows [13] = '{
		'{1'h0, 8'h44, 8'h00, 8'h67}, '{1'h0, 8'h48, 8'h00, 8'h00},
		'{1'h0, 8'h50, 8'h00, 8'h00}, '{1'h1, 8'h48, 8'hFF, 8'h00},
		'{1'h0, 8'h48, 8'h00, 8'h1F}, '{1'h1, 8'h4C, 8'hFF, 8'h00},
		'{1'h0, 8'h4C, 8'h00, 8'h08}, '{1'h1, 8'h44, 8'hFF, 8'h00},
		'{1'h0, 8'h44, 8'h00, 8'hE7}, '{1'h1, 8'h44, 8'h00, 8'h00},
		'{1'h0, 8'h44, 8'h00, 8'h67}, '{1'h1, 8'h20, 8'hFF, 8'h00},
		'{1'h0, 8'h20, 8'h00, 8'h00}};

	erai_top #(.LOF_SHORT_CYCLES(20), .LOF_LONG_CYCLES(60)) dut_u (
		.core_clk(core_clk), .reset_n(reset_n), .avm_req(avm_req),
		.avm_readdata(rdata), .avm_waitrequest(wreq), .rx_in(rx),
		.signal_loss_state(los), .active_alignment(act_al), .out_of_frame_state(oof),
		.frame_loss_state(lof), .alarm_indication_state(ais),
		.far_end_failure_state(ferf), .irq_n(irq_n));
	erai_far_end #(.FRAME_BITS(FB)) far_u (
		.core_clk(core_clk), .reset_n(reset_n), .zeros(zeros), .a_val(a_val),
		.fas_val(fas_val), .resync_req(rsy), .resync_at(rsy_pos), .rx(rx));

	initial begin
		core_clk = 1'h0;
		forever #50 core_clk = ~core_clk;
	end
////////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int i;
		@(posedge core_clk);
		avm_req <= '{!wr, wr, a, {24'h000000, d}, 4'hF};
		for (i = 0; i < 20; i++) begin
			@(posedge core_clk);
			if (wreq === 1'h0) break;
		end
		rd = rdata[7:0];
		avm_req.read <= 1'h0;
		avm_req.write <= 1'h0;
		if (i == 20) begin
			n_fail++;
			report_and_stop();
		end
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
		bus(1'h0, a, 8'h00);
		check(nm, rd, e);
	endtask
	// Waits on one of lof, oof, ais, ferf and returns the cycles it took.
	task automatic wait_bit(input int b, input logic v, output int n);
		for (n = 0; n < 400; n++) begin
			@(posedge core_clk);
			if (st[b] === v) return;
		end
		n_fail++;
		report_and_stop();
	endtask
	task automatic wait_frames(input int k);
		for (int i = 0; k > 0 && i < 200; i++) begin
			@(posedge core_clk);
			if (rx.frame_start === 1'h1) k--;
		end
		if (k > 0) begin
			n_fail++;
			report_and_stop();
		end
	endtask
	task automatic resync(input logic [7:0] p);
		@(posedge core_clk);
		rsy <= 1'h1;
		rsy_pos <= p;
		@(posedge core_clk);
		rsy <= 1'h0;
	endtask
////////////////////////////////////////////////////////////////////////////////
	initial begin
		int n;
		reset_n = 1'h0;
		avm_req = '0;
		los = 1'h0;
		zeros = 8'h08;
		a_val = 1'h1;
		fas_val = 1'h0;
		rsy = 1'h0;
		rsy_pos = 8'h00;
		repeat (12) @(posedge core_clk);
		reset_n <= 1'h1;
		for (int i = 0; i < 13; i++) begin
			bus(rows[i].wr, rows[i].a, rows[i].d);
			if (!rows[i].wr) check("reg row", rd, rows[i].e);
		end
		$display("register test done");
		bus(1'h1, 8'h48, 8'h01);
		zeros <= 8'h04;
		wait_frames(4);
		check("ais eight", {7'h00, ais}, 8'h00);
		zeros <= 8'h03;
		wait_bit(1, 1'h1, n);
		repeat (2) @(posedge core_clk);
		check("irq ais", {7'h00, irq_n}, 8'h00);
		rchk("st1 ais", 8'h50, 8'h01);
		// The host reads the live alarm bit here to decide whether to send far-end failure.
		rchk("cfg2 ais", 8'h44, 8'h6F);
		repeat (2) @(posedge core_clk);
		check("irq freed", {7'h00, irq_n}, 8'h01);
		rchk("st1 cleared", 8'h50, 8'h00);
		zeros <= 8'h04;
		wait_frames(4);
		check("ais kept", {7'h00, ais}, 8'h01);
		zeros <= 8'h08;
		wait_bit(1, 1'h0, n);
		rchk("st1 ais off", 8'h50, 8'h01);
		$display("alarm indication test done");
		bus(1'h1, 8'h48, 8'h00);
		zeros <= 8'h03;
		wait_bit(1, 1'h1, n);
		repeat (2) @(posedge core_clk);
		check("irq masked", {7'h00, irq_n}, 8'h01);
		rchk("st1 masked", 8'h50, 8'h00);
		$display("mask test done");
		los <= 1'h1;
		a_val <= 1'h0;
		wait_bit(0, 1'h0, n);
		repeat (2) @(posedge core_clk);
		check("irq ferf", {7'h00, irq_n}, 8'h00);
		rchk("st2 ferf off", 8'h54, 8'h08);
		rchk("cfg2 live", 8'h44, 8'h7E);
		a_val <= 1'h1;
		wait_bit(0, 1'h1, n);
		rchk("st2 ferf on", 8'h54, 8'h08);
		repeat (2) @(posedge core_clk);
		check("irq ferf off", {7'h00, irq_n}, 8'h01);
		$display("far-end failure test done");
		bus(1'h1, 8'h48, 8'h14);
		resync(8'h00);
		wait_bit(3, 1'h0, n);
		rchk("st1 same align", 8'h50, 8'h04);
		fas_val <= 1'h1;
		wait_frames(3);
		@(posedge core_clk);
		check("oof third", {7'h00, oof}, 8'h00);
		wait_bit(2, 1'h1, n);
		check("oof fourth", {7'h00, n <= FB}, 8'h01);
		check("align kept", act_al, 8'h00);
		repeat (12) @(posedge core_clk);
		check("lof early", {7'h00, lof}, 8'h00);
		wait_bit(3, 1'h1, n);
		check("lof time", {7'h00, n <= 10}, 8'h01);
		rchk("st1 lof on", 8'h50, 8'h04);
		fas_val <= 1'h0;
		resync(8'h5A);
		wait_bit(2, 1'h0, n);
		check("align new", act_al, 8'h5A);
		rchk("st1 new align", 8'h50, 8'h14);
		$display("framing test done");
		report_and_stop();
	end
endmodule
